// ==== uvf_host_model.sv ====
module uvf_host_model
  import uvf_pkg::*;
(
  // Free link clock in, gated link clock out
  input wire logic lclk_free,
  output logic link_clk,
  // Command port
  output logic cmd_valid,
  output uvf_cmd_t cmd,
  input wire logic cmd_ready,
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_data
);
  timeunit 1ns;
  timeprecision 100ps;

  logic run = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Clock stands low between commands; gate moves only while the free clock is low
  assign link_clk = lclk_free & run;

  initial begin
    cmd_valid = 1'b0;
    cmd = '0;
  end

  // One command: offer, hold until taken, then wait for the answer pulse
  task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] data,
                      input int gap, output logic [15:0] rdata);
    @(negedge lclk_free);
    run = 1'b1;
    repeat (gap) @(negedge lclk_free);
    cmd_valid = 1'b1;
    cmd = '{write: wr, code: code, data: data};
    do @(posedge link_clk); while (cmd_ready !== 1'b1);
    @(negedge lclk_free);
    cmd_valid = 1'b0;
    cmd = ~cmd; // Released bus no longer shows the last command
    do @(posedge link_clk); while (rsp_valid !== 1'b1);
    rdata = rsp_data;
    @(negedge lclk_free);
    run = 1'b0;
  endtask : xfer

endmodule : uvf_host_model

// ==== uvf_input_uv_resp.sv ====
// Notes on behaviour
// - Sixteen-bit undervoltage threshold in linear format, host writes and reads it.
// - Any fault, whatever the mode, pulls the alert low and sets status.
// - Mode 00 keeps the output regulating through the fault.
// - Mode 01 runs on for the delay, then follows the retry setting.
// - Mode 10 shuts the output at once, then follows the retry setting.
// - Mode 11 holds the output off while the fault lasts, then resumes.
// - Retry setting 000 makes no restart; output stays off until cleared.
// - When all allowed restarts fail, output stays off until cleared.
// - Retry setting 001 to 110 allows one to six restarts.
// - Retry setting 111 restarts without limit until disabled or reset.
// - Restart attempts are spaced by delay field times 8.2 ms.
// - Run-on time after the fault is delay field times 10 ms.
// - Status byte bit 3 reads one once an undervoltage fault occurred.
module uvf_input_uv_resp
  import uvf_pkg::*;
#(
  parameter int OPERATE_UNIT_CYC = OPERATE_UNIT_CYC_DFLT,
  parameter int RETRY_UNIT_CYC = RETRY_UNIT_CYC_DFLT
) (
  // Core clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Host command port on the link clock
  input wire logic link_clk,
  input wire logic cmd_valid,
  input wire uvf_cmd_t cmd,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [15:0] rsp_data,
  // Converter side, core domain
  input wire logic [15:0] vin_meas,
  input wire logic out_en_req,
  output logic out_enable,
  // Open-drain alert pin
  output logic alert_output_low_out,
  output logic alert_output_low_oe
);

  localparam int TICK_W = $clog2((OPERATE_UNIT_CYC > RETRY_UNIT_CYC ?
                                  OPERATE_UNIT_CYC : RETRY_UNIT_CYC) + 1);
  localparam logic [TICK_W-1:0] OPER_RELOAD = TICK_W'(OPERATE_UNIT_CYC - 1);
  localparam logic [TICK_W-1:0] RETRY_RELOAD = TICK_W'(RETRY_UNIT_CYC - 1);

  uvf_cmd_t held_cmd;
  logic req_tgl;
  logic req_s;
  logic req_seen_q;
  logic ack_tgl_q;
  logic exec;
  logic clr_pulse;
  logic [15:0] rd_word_q;
  logic [15:0] thr_q;
  logic [7:0] act_q;
  logic [1:0] mode;
  logic [2:0] retry_set;
  logic [2:0] delay_set;
  logic vin_low;
  logic uv_flag_q;
  uvf_state_t state_q;
  uvf_state_t state_d;
  logic [2:0] retry_lim_q;
  logic [2:0] tries_q;
  logic tmr_load;
  logic [TICK_W-1:0] tmr_reload;
  logic [TICK_W-1:0] tick_q;
  logic [TICK_W-1:0] unit_q;
  logic [2:0] units_q;
  logic tmr_done;
  logic retry_left;
  logic out_en_q;

  ////////////////////////////////////////////////////////////////////////////
  // Link side and crossing
  uvf_link_port u_link (
    .link_clk(link_clk),
    .arst_n(arst_n),
    .cmd_valid(cmd_valid),
    .cmd(cmd),
    .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid),
    .rsp_data(rsp_data),
    .held_cmd(held_cmd),
    .req_tgl(req_tgl),
    .ack_tgl(ack_tgl_q),
    .rd_word(rd_word_q)
  );

  uvf_sync2 #(.W(1)) u_req_sync (
    .clk(core_clk),
    .arst_n(arst_n),
    .d(req_tgl),
    .q(req_s)
  );

  // held_cmd is quiet by the time the toggle has passed two flops
  assign exec = (req_s != req_seen_q);
  assign clr_pulse = exec && held_cmd.write && (held_cmd.code == CODE_CLEAR_FAULTS);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      req_seen_q <= 1'b0;
      ack_tgl_q <= 1'b0;
    end else if (exec) begin
      req_seen_q <= req_s;
      ack_tgl_q <= ~ack_tgl_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      thr_q <= UV_THRESH_RST;
      act_q <= UV_ACTION_RST;
    end else if (exec && held_cmd.write) begin
      if (held_cmd.code == CODE_UV_THRESH) begin
        thr_q <= held_cmd.data;
      end
      if (held_cmd.code == CODE_UV_ACTION) begin
        act_q <= held_cmd.data[7:0];
      end
    end
  end

  // Read word is captured once per command and held for the link side
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_word_q <= '0;
    end else if (exec) begin
      case (held_cmd.code)
        CODE_UV_THRESH: rd_word_q <= thr_q;
        CODE_UV_ACTION: rd_word_q <= {8'h00, act_q};
        CODE_STATUS_BYTE: begin
          rd_word_q <= '0;
          rd_word_q[STAT_UV_BIT] <= uv_flag_q;
          rd_word_q[STAT_OFF_BIT] <= !out_en_q;
        end
        default: rd_word_q <= '0;
      endcase
    end
  end

  assign mode = act_q[ACT_MODE_LSB +: 2];
  assign retry_set = act_q[ACT_RETRY_LSB +: 3];
  assign delay_set = act_q[ACT_DELAY_LSB +: 3];

  ////////////////////////////////////////////////////////////////////////////
  // Detection and sticky status; a new fault wins over a clear
  assign vin_low = uvf_lin_scale(vin_meas) < uvf_lin_scale(thr_q);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      uv_flag_q <= 1'b0;
    end else if (vin_low && out_en_req) begin
      uv_flag_q <= 1'b1;
    end else if (clr_pulse) begin
      uv_flag_q <= 1'b0;
    end
  end

  // Alert pulled low while the flag stands, in every mode
  assign alert_output_low_out = 1'b0;
  assign alert_output_low_oe = uv_flag_q;

  ////////////////////////////////////////////////////////////////////////////
  // Delay timer: whole units of the selected length
  // Done already in the last cycle of the last unit, so the decision edge is exactly
  // delay times unit after the load; waiting for units_q to reach zero would add a cycle
  assign tmr_done = (units_q == 3'h0) || ((units_q == 3'h1) && (tick_q == '0));

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      units_q <= '0;
      tick_q <= '0;
      unit_q <= '0;
    end else if (tmr_load) begin
      units_q <= delay_set;
      tick_q <= tmr_reload;
      unit_q <= tmr_reload;
    end else if (!tmr_done) begin
      if (tick_q == '0) begin
        units_q <= units_q - 3'h1;
        tick_q <= unit_q;
      end else begin
        tick_q <= tick_q - 1'b1;
      end
    end
  end

  // A failed attempt may be followed by another one
  assign retry_left = (retry_lim_q == RETRY_FOREVER) || ((tries_q + 3'h1) < retry_lim_q);

  ////////////////////////////////////////////////////////////////////////////
  // Response state machine
  always_comb begin
    state_d = state_q;
    tmr_load = 1'b0;
    tmr_reload = RETRY_RELOAD;
    case (state_q)
      ST_OFF: begin
        if (out_en_req) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (vin_low) begin
          case (mode)
            MODE_IGNORE: state_d = ST_RUN;
            MODE_OPERATE: begin
              state_d = ST_DELAY;
              tmr_load = 1'b1;
              tmr_reload = OPER_RELOAD;
            end
            MODE_DISABLE: begin
              state_d = (retry_set == RETRY_NONE) ? ST_LATCH : ST_WAIT;
              tmr_load = 1'b1;
            end
            default: state_d = ST_HOLD;
          endcase
        end
      end
      ST_DELAY: begin
        if (!vin_low) begin
          state_d = ST_RUN;
        end else if (tmr_done) begin
          state_d = (retry_lim_q == RETRY_NONE) ? ST_LATCH : ST_WAIT;
          tmr_load = 1'b1;
        end
      end
      ST_WAIT: begin
        if (tmr_done) begin
          if (!vin_low) begin
            state_d = ST_RUN;
          end else if (retry_left) begin
            tmr_load = 1'b1;
          end else begin
            state_d = ST_LATCH;
          end
        end
      end
      ST_LATCH: begin
        if (clr_pulse && !vin_low) begin
          state_d = ST_RUN;
        end
      end
      ST_HOLD: begin
        if (!vin_low) begin
          state_d = ST_RUN;
        end
      end
      default: state_d = ST_OFF;
    endcase
    // Disabling the output ends every response, endless retry included
    if (!out_en_req) begin
      state_d = ST_OFF;
      tmr_load = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  // Retry setting frozen at fault entry so a rewrite cannot skew the count
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      retry_lim_q <= RETRY_NONE;
      tries_q <= '0;
    end else if (state_q == ST_RUN && state_d != ST_RUN) begin
      retry_lim_q <= retry_set;
      tries_q <= '0;
    end else if (state_q == ST_WAIT && tmr_load) begin
      tries_q <= tries_q + 3'h1;
    end
  end

  // Output on only in run and run-on states
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      out_en_q <= 1'b0;
    end else begin
      out_en_q <= (state_d == ST_RUN) || (state_d == ST_DELAY);
    end
  end

  assign out_enable = out_en_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  chk_thresh_write: assert property (
    exec && held_cmd.write && held_cmd.code == CODE_UV_THRESH
    |=> thr_q == $past(held_cmd.data))
    else $error("threshold write not stored");

  chk_alert_on_fault: assert property (
    vin_low && out_en_req |=> alert_output_low_oe && uv_flag_q)
    else $error("fault did not raise alert and status");

  chk_ignore_runs: assert property (
    state_q == ST_RUN && mode == MODE_IGNORE && out_en_req |=> out_enable [*2])
    else $error("ignore mode interrupted the output");

  chk_delay_on: assert property (
    state_q == ST_DELAY && out_en_req |=> out_enable || state_q != ST_DELAY)
    else $error("output dropped during run-on delay");

  chk_disable_now: assert property (
    state_q == ST_RUN && vin_low && mode == MODE_DISABLE && out_en_req
    |=> !out_enable)
    else $error("disable mode did not shut output");

  chk_hold_release: assert property (
    state_q == ST_HOLD && !vin_low && out_en_req |=> out_enable)
    else $error("hold mode did not resume output");

  chk_hold_off: assert property (
    state_q == ST_HOLD && vin_low |=> !out_enable)
    else $error("output on while fault present in hold mode");

  chk_no_retry: assert property (
    state_q == ST_WAIT |-> retry_lim_q != RETRY_NONE)
    else $error("retry wait entered with retries off");

  chk_give_up: assert property (
    state_q == ST_WAIT && tmr_done && vin_low && out_en_req
    && retry_lim_q != RETRY_FOREVER && tries_q + 3'h1 >= retry_lim_q
    |=> state_q == ST_LATCH ##1 !out_enable)
    else $error("exhausted retries did not latch off");

  chk_tries_bound: assert property (
    state_q == ST_WAIT && retry_lim_q != RETRY_FOREVER |-> tries_q < retry_lim_q)
    else $error("more restart attempts than allowed");

  chk_endless_retry: assert property (
    state_q == ST_WAIT && retry_lim_q == RETRY_FOREVER && out_en_req
    |=> state_q != ST_LATCH)
    else $error("endless retry gave up");

  chk_retry_unit: assert property (
    tmr_load && state_d == ST_WAIT
    |=> unit_q == RETRY_RELOAD && units_q == $past(delay_set))
    else $error("retry interval loaded wrong");

  chk_operate_unit: assert property (
    tmr_load && state_d == ST_DELAY |=> unit_q == OPER_RELOAD)
    else $error("run-on unit loaded wrong");

  chk_status_bit: assert property (
    exec && held_cmd.code == CODE_STATUS_BYTE
    |=> rd_word_q[STAT_UV_BIT] == $past(uv_flag_q))
    else $error("status bit does not show the fault flag");

  chk_detect: assert property (
    !vin_low && out_en_req && state_q == ST_RUN |=> state_q != ST_HOLD)
    else $error("hold entered without undervoltage");

endmodule : uvf_input_uv_resp

// ==== uvf_input_uv_resp_bench.sv ====
module uvf_input_uv_resp_bench
  import uvf_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // Short unit counts keep the run brief; the retry and run-on waits derive from them
  localparam int OPU = 20;
  localparam int RTU = 16;
  localparam int CYC_MAX = 20000;
  localparam logic [15:0] TH = 16'h0064;
  localparam logic [15:0] VLO = 16'h0063;
  localparam logic [15:0] VOK = 16'h00C8;

  logic core_clk = 1'b0;
  logic lclk_free = 1'b0;
  logic arst_n;
  logic link_clk;
  logic cmd_valid;
  uvf_cmd_t cmd;
  logic cmd_ready;
  logic rsp_valid;
  logic [15:0] rsp_data;
  logic [15:0] vin_meas;
  logic out_en_req;
  logic out_enable;
  logic alert_out;
  logic alert_oe;
  int err_total = 0;
  int n_tests = 0;
  int cyc = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Clocks: link clock offset so the two never share phase
  initial forever #4 core_clk = ~core_clk;

  initial begin
    #1.3;
    forever #3 lclk_free = ~lclk_free;
  end

  uvf_input_uv_resp #(.OPERATE_UNIT_CYC(OPU), .RETRY_UNIT_CYC(RTU)) uut (
    .core_clk(core_clk), .arst_n(arst_n), .link_clk(link_clk),
    .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .vin_meas(vin_meas),
    .out_en_req(out_en_req), .out_enable(out_enable),
    .alert_output_low_out(alert_out), .alert_output_low_oe(alert_oe)
  );

  uvf_host_model host (
    .lclk_free(lclk_free), .link_clk(link_clk), .cmd_valid(cmd_valid), .cmd(cmd),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Shared helpers
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : wait_cyc

  task automatic set_vin(input logic [15:0] v);
    @(negedge core_clk);
    vin_meas = v;
  endtask : set_vin

  task automatic wr(input logic [7:0] code, input logic [15:0] data);
    logic [15:0] d;
    host.xfer(1'b1, code, data, 0, d);
  endtask : wr

  task automatic rd(input logic [7:0] code, input int gap, output logic [15:0] d);
    host.xfer(1'b0, code, 16'h0000, gap, d);
  endtask : rd

  // Program the action, drop the input below threshold, expect the alert next edge
  task automatic go_fault(input logic [7:0] act);
    wr(CODE_UV_ACTION, {8'h00, act});
    set_vin(VLO);
    wait_cyc(1);
    check(16'(alert_oe), 16'h0001);
    check(16'(alert_out), 16'h0000);
  endtask : go_fault

  // Clearing with the fault gone must bring the output back and drop the alert
  task automatic recover();
    set_vin(VOK);
    wr(CODE_CLEAR_FAULTS, 16'h0000);
    wait_cyc(4);
    check(16'(out_enable), 16'h0001);
    check(16'(alert_oe), 16'h0000);
  endtask : recover

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_regs();
    logic [15:0] d;
    rd(CODE_UV_THRESH, 0, d);
    check(d, UV_THRESH_RST);
    rd(CODE_UV_ACTION, 2, d);
    check(16'(d[7:0]), 16'(UV_ACTION_RST));
    wr(CODE_UV_THRESH, 16'hA5C3);
    rd(CODE_UV_THRESH, 0, d);
    check(d, 16'hA5C3);
    wr(CODE_UV_ACTION, 16'h005B);
    rd(CODE_UV_ACTION, 0, d);
    check(16'(d[7:0]), 16'h005B);
    rd(8'h5B, 3, d);
    check(d, 16'h0000);
    wr(CODE_UV_THRESH, TH);
    rd(CODE_STATUS_BYTE, 0, d);
    check(16'(d[STAT_UV_BIT]), 16'h0000);
  endtask : t_regs

  // Ignore mode: boundary at the threshold, then a real fault with output kept on
  task automatic t_ignore();
    logic [15:0] d;
    wr(CODE_UV_ACTION, 16'h0000);
    set_vin(TH);
    wait_cyc(3);
    check(16'(alert_oe), 16'h0000);
    go_fault(8'h00);
    wait_cyc(60);
    check(16'(out_enable), 16'h0001);
    rd(CODE_STATUS_BYTE, 0, d);
    check(16'(d[STAT_UV_BIT]), 16'h0001);
    recover();
    rd(CODE_STATUS_BYTE, 0, d);
    check(16'(d[STAT_UV_BIT]), 16'h0000);
  endtask : t_ignore

  // Disable with no retry: stays off after the fault goes until cleared
  task automatic t_no_retry();
    logic [15:0] d;
    go_fault({MODE_DISABLE, RETRY_NONE, 3'h1});
    check(16'(out_enable), 16'h0000);
    set_vin(VOK);
    wait_cyc(100);
    check(16'(out_enable), 16'h0000);
    rd(CODE_STATUS_BYTE, 0, d);
    check(16'(d[STAT_OFF_BIT]), 16'h0001);
    recover();
  endtask : t_no_retry

  // Every retry count: fault outlives n-1 attempts, attempt n succeeds on time
  task automatic t_retry();
    int n;
    for (int r = 1; r < 8; r++) begin
      n = (r == 7) ? 9 : r;
      go_fault({MODE_DISABLE, 3'(r), 3'h2});
      wait_cyc((n - 1) * 2 * RTU + RTU);
      set_vin(VOK);
      wait_cyc(8);
      check(16'(out_enable), 16'h0000);
      wait_cyc(14);
      check(16'(out_enable), 16'h0001);
      recover();
    end
    // Fault outlasts both allowed attempts: latched off
    go_fault({MODE_DISABLE, 3'h2, 3'h2});
    wait_cyc(2 * 2 * RTU + RTU);
    set_vin(VOK);
    wait_cyc(2 * RTU);
    check(16'(out_enable), 16'h0000);
    recover();
  endtask : t_retry

  // Run-on mode: fault that ends in the delay, then one that outlasts it
  task automatic t_operate();
    go_fault({MODE_OPERATE, RETRY_NONE, 3'h2});
    wait_cyc(15);
    set_vin(VOK);
    wait_cyc(50);
    check(16'(out_enable), 16'h0001);
    recover();
    go_fault({MODE_OPERATE, RETRY_NONE, 3'h2});
    wait_cyc(2 * OPU - 8);
    check(16'(out_enable), 16'h0001);
    wait_cyc(14);
    check(16'(out_enable), 16'h0000);
    recover();
  endtask : t_operate

  // Hold mode: off while the fault lasts, back on by itself, alert stays
  task automatic t_hold();
    go_fault({MODE_HOLD, RETRY_NONE, 3'h1});
    wait_cyc(80);
    check(16'(out_enable), 16'h0000);
    set_vin(VOK);
    wait_cyc(3);
    check(16'(out_enable), 16'h0001);
    check(16'(alert_oe), 16'h0001);
    recover();
  endtask : t_hold

  // Output not wanted: off bit in the status byte follows
  task automatic t_enable();
    logic [15:0] d;
    @(negedge core_clk);
    out_en_req = 1'b0;
    wait_cyc(2);
    check(16'(out_enable), 16'h0000);
    rd(CODE_STATUS_BYTE, 0, d);
    check(16'(d[STAT_OFF_BIT]), 16'h0001);
    @(negedge core_clk);
    out_en_req = 1'b1;
    wait_cyc(2);
    check(16'(out_enable), 16'h0001);
  endtask : t_enable

  ////////////////////////////////////////////////////////////////////////////
  // Closing report, reached from the main sequence or the hang guard
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test

  // Hang guard: a stuck handshake would otherwise run forever
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == CYC_MAX) begin
      err_total++;
      end_of_test();
    end
  end

  // Main sequence
  initial begin
    arst_n = 1'b0;
    vin_meas = VOK;
    out_en_req = 1'b1;
    repeat (6) @(negedge core_clk);
    arst_n = 1'b1;
    wait_cyc(2);
    t_regs();
    t_ignore();
    t_no_retry();
    t_retry();
    t_operate();
    t_hold();
    t_enable();
    end_of_test();
  end

endmodule : uvf_input_uv_resp_bench

// ==== uvf_link_port.sv ====
module uvf_link_port
  import uvf_pkg::*;
(
  // Link clock and reset
  input wire logic link_clk,
  input wire logic arst_n,
  // Host command and answer, link domain
  input wire logic cmd_valid,
  input wire uvf_cmd_t cmd,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [15:0] rsp_data,
  // Crossing to the core domain
  output uvf_cmd_t held_cmd,
  output logic req_tgl,
  input wire logic ack_tgl,
  input wire logic [15:0] rd_word
);
  logic busy_q;
  logic ack_seen_q;
  logic ack_s;

  uvf_sync2 #(.W(1)) u_ack_sync (
    .clk(link_clk),
    .arst_n(arst_n),
    .d(ack_tgl),
    .q(ack_s)
  );

  // One command in flight; held_cmd stays still until the ack returns
  assign cmd_ready = !busy_q;

  ////////////////////////////////////////////////////////////////////////////
  // Request toggle and held command
  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      held_cmd <= '0;
      req_tgl <= 1'b0;
    end else if (cmd_valid && !busy_q) begin
      held_cmd <= cmd;
      req_tgl <= ~req_tgl;
    end
  end

  // Busy until the core flips its ack; core holds rd_word stable meanwhile
  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_q <= 1'b0;
      ack_seen_q <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data <= '0;
    end else begin
      rsp_valid <= 1'b0;
      if (cmd_valid && !busy_q) begin
        busy_q <= 1'b1;
      end else if (busy_q && (ack_s != ack_seen_q)) begin
        busy_q <= 1'b0;
        ack_seen_q <= ack_s;
        rsp_valid <= 1'b1;
        rsp_data <= rd_word;
      end
    end
  end
endmodule : uvf_link_port

// ==== uvf_pkg.sv ====
package uvf_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Command codes of the registers
  localparam logic [7:0] CODE_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CODE_UV_THRESH = 8'h59;
  localparam logic [7:0] CODE_UV_ACTION = 8'h5A;
  localparam logic [7:0] CODE_STATUS_BYTE = 8'h78;

  // Reset values
  localparam logic [15:0] UV_THRESH_RST = 16'h0000;
  localparam logic [7:0] UV_ACTION_RST = 8'h80;

  // Field positions of the action byte and the status byte
  localparam int ACT_MODE_LSB = 6;
  localparam int ACT_RETRY_LSB = 3;
  localparam int ACT_DELAY_LSB = 0;
  localparam int STAT_UV_BIT = 3;
  localparam int STAT_OFF_BIT = 6;

  // Response modes and retry settings
  localparam logic [1:0] MODE_IGNORE = 2'h0;
  localparam logic [1:0] MODE_OPERATE = 2'h1;
  localparam logic [1:0] MODE_DISABLE = 2'h2;
  localparam logic [1:0] MODE_HOLD = 2'h3;
  localparam logic [2:0] RETRY_NONE = 3'h0;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;

  // Timing: unit times as printed, cycle counts derived from the clock
  localparam int CLK_MHZ = 125;
  localparam real OPERATE_UNIT_MS = 10.0;
  localparam real RETRY_UNIT_MS = 8.2;
  localparam int OPERATE_UNIT_CYC_DFLT = $rtoi(OPERATE_UNIT_MS * 1000.0 * CLK_MHZ);
  localparam int RETRY_UNIT_CYC_DFLT = $rtoi(RETRY_UNIT_MS * 1000.0 * CLK_MHZ);

  ////////////////////////////////////////////////////////////////////////////
  // One host command as it crosses from the link side
  typedef struct packed {
    logic write;
    logic [7:0] code;
    logic [15:0] data;
  } uvf_cmd_t;

  typedef enum logic [2:0] {
    ST_OFF, ST_RUN, ST_DELAY, ST_WAIT, ST_LATCH, ST_HOLD
  } uvf_state_t;

  // Linear word (5-bit exponent, 11-bit mantissa) scaled by 2^16, signed
  function automatic logic signed [42:0] uvf_lin_scale(input logic [15:0] w);
    logic signed [42:0] m;
    logic [4:0] sh;
    m = {{32{w[10]}}, w[10:0]};
    sh = {~w[15], w[14:11]};
    return m <<< sh;
  endfunction : uvf_lin_scale

endpackage : uvf_pkg

// ==== uvf_sync2.sv ====
module uvf_sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Level in and out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  // First stage is read only by the second
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule : uvf_sync2
